// ==== logic/fcds_pkg.sv ====
`default_nettype none
package fcds_pkg;
  // Register select codes for address-decoded commands
  localparam logic [3:0] CMD_SET_PTR    = 4'hC;
  localparam logic [3:0] CMD_CLR_PTR    = 4'hC;
  localparam logic [3:0] CMD_MCLR       = 4'hD;
  localparam logic [3:0] CMD_CLR_MODECNT = 4'hE;
  localparam logic [3:0] CMD_CLR_MASK   = 4'hE;
  localparam logic [3:0] SEL_MASK_ALL   = 4'hF;
  localparam logic [3:0] SEL_STATUS     = 4'h8;
  localparam logic [3:0] SEL_MODE       = 4'hB;
  localparam logic [3:0] SEL_REQ        = 4'h9;
  localparam logic [3:0] SEL_CMD        = 4'h8;
  localparam logic [3:0] SEL_MASK_ONE   = 4'hA;
  // Mode register field positions
  localparam int MODE_TYPE_LO  = 0;
  localparam int MODE_AUTO     = 2;
  localparam int MODE_DEC      = 3;
  localparam int MODE_MODE_LO  = 4;
  // Command register bit positions
  localparam int CMDB_M2M      = 0;
  localparam int CMDB_HOLD0    = 1;
  localparam int CMDB_DISABLE  = 2;
  localparam int CMDB_CHAN_REQUEST_LOW = 6;
  localparam int CMDB_CHAN_ACKNOWLEDGE_HI  = 7;
  // Reset values, then transfer type and service mode codes and other constants
  localparam logic [7:0] RST_CMD  = 8'h00;
  localparam logic [3:0] RST_MASK = 4'hF;
  localparam logic [1:0] XFER_VERIFY = 2'h0;
  localparam logic [1:0] XFER_WRITE  = 2'h1;
  localparam logic [1:0] XFER_READ   = 2'h2;
  localparam logic [1:0] SVC_DEMAND  = 2'h0;
  localparam logic [1:0] SVC_SINGLE  = 2'h1;
  localparam logic [1:0] SVC_BLOCK   = 2'h2;
  localparam logic [1:0] SVC_CASCADE = 2'h3;
  localparam logic [15:0] CNT_WRAP   = 16'hFFFF;
  localparam int SYNC_STAGES = 2;
  // Sequencer states, Gray along idle -> hold wait -> S1 -> S2 -> S3 -> WAIT -> S4
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_HOLD = 4'h1,
    ST_S1   = 4'h3,
    ST_S2   = 4'h2,
    ST_S3   = 4'h6,
    ST_WAIT = 4'h7,
    ST_S4   = 4'h5,
    ST_R1   = 4'h4,
    ST_R2   = 4'hC,
    ST_R3   = 4'hD,
    ST_R4   = 4'hF,
    ST_W1   = 4'hE,
    ST_W2   = 4'hA,
    ST_W3   = 4'hB,
    ST_W4   = 4'h9,
    ST_CASC = 4'h8
  } fcds_state_e;
endpackage : fcds_pkg
`default_nettype wire

// ==== logic/fcds_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module fcds_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule // fcds_sync
`default_nettype wire

// ==== logic/fcds_chan.sv ====
`timescale 1ns/1ps
`default_nettype none
// One channel's base and current address / count
module fcds_chan (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_wr_lo,
  input  wire logic        i_wr_hi,
  input  wire logic        i_sel_cnt,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_step,
  input  wire logic        i_hold_addr,
  input  wire logic        i_dec,
  input  wire logic        i_reload,
  output logic      [15:0] o_addr,
  output logic      [15:0] o_count,
  output logic             o_wrap
);
  logic [15:0] base_addr;
  logic [15:0] base_count;
  wire  [15:0] step_addr = i_dec ? o_addr - 16'h0001 : o_addr + 16'h0001;
  wire  [15:0] next_addr = i_hold_addr ? o_addr : step_addr;
  assign o_wrap = (o_count == 16'h0000);
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      base_addr  <= 16'h0000;
      base_count <= 16'h0000;
      o_addr     <= 16'h0000;
      o_count    <= 16'h0000;
    end else if (i_wr_lo || i_wr_hi) begin
      if (i_sel_cnt) begin
        base_count <= i_wr_hi ? {i_data, base_count[7:0]}
                              : {base_count[15:8], i_data};
        o_count    <= i_wr_hi ? {i_data, base_count[7:0]}
                              : {base_count[15:8], i_data};
      end else begin
        base_addr <= i_wr_hi ? {i_data, base_addr[7:0]}
                             : {base_addr[15:8], i_data};
        o_addr    <= i_wr_hi ? {i_data, base_addr[7:0]}
                             : {base_addr[15:8], i_data};
      end
    end else if (i_step && i_reload) begin
      o_addr  <= base_addr;
      o_count <= base_count;
    end else if (i_step) begin
      o_addr  <= next_addr;
      o_count <= o_count - 16'h0001;
    end
  end
endmodule // fcds_chan
`default_nettype wire

// ==== logic/fcds_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module fcds_core #(
  parameter int NCH = 4
) (
  input  wire logic           i_sys_clk,
  input  wire logic           i_rst_b,
  input  wire logic [NCH-1:0] i_chan_request,
  input  wire logic           i_bus_hold_grant,
  input  wire logic           i_ready,
  input  wire logic           i_end_of_process_n,
  input  wire logic           i_chip_select_n,
  input  wire logic           i_io_read_strobe_n,
  input  wire logic           i_io_write_strobe_n,
  input  wire logic [3:0]     i_register_select_lines,
  input  wire logic [7:0]     i_data,
  output logic      [7:0]     o_data,
  output logic                o_data_oe,
  output logic      [15:0]    o_addr,
  output logic                o_addr_oe,
  output logic                o_bus_hold_request,
  output logic      [NCH-1:0] o_chan_acknowledge,
  output logic                o_memory_read_strobe_n,
  output logic                o_memory_write_strobe_n,
  output logic                o_io_read_strobe_n,
  output logic                o_io_write_strobe_n,
  output logic                o_ctrl_oe,
  output logic                o_end_of_process_n,
  output logic                o_end_of_process_oe,
  output logic      [7:0]     o_status
);
  logic [NCH-1:0]  req_s;
  logic            grant;
  logic            rdy;
  logic            eop_in;
  logic            cs_n;
  logic            rd_n;
  logic            wr_n;
  logic            wr_d;
  logic            rd_d;
  logic [3:0]      sel;
  logic [7:0]      din;
  fcds_pkg::fcds_state_e state;
  fcds_pkg::fcds_state_e next_state;
  logic [7:0]      cmd;
  logic [5:0]      mode [NCH];
  logic [NCH-1:0]  mask;
  logic [NCH-1:0]  sw_req;
  logic [NCH-1:0]  tc_flag;
  logic            byte_ptr;
  logic [1:0]      chan;
  logic            eop_pend;
  logic [7:0]      temp;
  logic [15:0]     ch_addr [NCH];
  logic [15:0]     ch_count [NCH];
  logic [NCH-1:0]  ch_wrap;
  logic [NCH-1:0]  ch_step;
  logic [NCH-1:0]  ch_reload;

  fcds_sync #(.WIDTH(NCH + 18)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_async   ({i_chan_request, i_bus_hold_grant, i_ready,
                 i_end_of_process_n, i_chip_select_n, i_io_read_strobe_n,
                 i_io_write_strobe_n, i_register_select_lines, i_data}),
    .o_sync    ({req_s, grant, rdy, eop_in, cs_n, rd_n, wr_n, sel, din})
  );

  // Program condition and strobe edges
  wire prog    = !cs_n && !grant;
  wire wr_rise = prog && wr_n && !wr_d;
  wire rd_fall = prog && !rd_n && rd_d;
  wire cmd_sel = sel[3];
  wire wr_cmd  = wr_rise && cmd_sel && (sel[2:0] == 3'h0);
  wire wr_req  = wr_rise && cmd_sel && (sel[2:0] == 3'h1);
  wire wr_msk1 = wr_rise && cmd_sel && (sel[2:0] == 3'h2);
  wire wr_mode = wr_rise && cmd_sel && (sel[2:0] == 3'h3);
  wire clr_ptr = wr_rise && cmd_sel && (sel[2:0] == 3'h4);
  wire set_ptr = rd_fall && cmd_sel && (sel[2:0] == 3'h4);
  wire mclr    = wr_rise && cmd_sel && (sel[2:0] == 3'h5);
  wire clr_msk = wr_rise && cmd_sel && (sel[2:0] == 3'h6);
  wire wr_mall = wr_rise && cmd_sel && (sel[2:0] == 3'h7);
  wire rd_stat = rd_fall && cmd_sel && (sel[2:0] == 3'h0);
  wire wr_chan = wr_rise && !cmd_sel;
  wire [1:0] wsel_ch = sel[2:1];

  // Request detection
  wire [NCH-1:0] req_act = cmd[fcds_pkg::CMDB_CHAN_REQUEST_LOW] ? ~req_s : req_s;
  wire [NCH-1:0] pending = (req_act & ~mask) | sw_req;
  wire [1:0]     pick    = pending[0] ? 2'd0 : pending[1] ? 2'd1 :
                           pending[2] ? 2'd2 : 2'd3;
  wire           any_req = |pending && !cmd[fcds_pkg::CMDB_DISABLE];
  wire [5:0]     cm      = mode[chan];
  wire [1:0]     svc     = cm[fcds_pkg::MODE_MODE_LO+1:fcds_pkg::MODE_MODE_LO];
  wire [1:0]     xtype   = cm[fcds_pkg::MODE_TYPE_LO+1:fcds_pkg::MODE_TYPE_LO];
  wire           m2m     = cmd[fcds_pkg::CMDB_M2M] && chan == 2'd0;
  wire           ext_eop = !eop_in && svc != fcds_pkg::SVC_CASCADE;
  wire           last    = (state == fcds_pkg::ST_S4 || state == fcds_pkg::ST_W4);
  wire [1:0]     xfer_ch = m2m ? 2'd1 : chan;
  wire           cnt_end = ch_wrap[xfer_ch];
  wire           stop    = cnt_end || ext_eop || eop_pend;
  wire           still   = pending[chan];
  wire           keep_on = !stop && (svc == fcds_pkg::SVC_BLOCK ||
                           (svc == fcds_pkg::SVC_DEMAND && still));

  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      fcds_pkg::ST_IDLE: if (any_req && !grant)
                           next_state = fcds_pkg::ST_HOLD;
      fcds_pkg::ST_HOLD: if (grant) begin
        if (svc == fcds_pkg::SVC_CASCADE) next_state = fcds_pkg::ST_CASC;
        else if (m2m) next_state = fcds_pkg::ST_R1;
        else next_state = fcds_pkg::ST_S1;
      end
      fcds_pkg::ST_S1:   next_state = fcds_pkg::ST_S2;
      fcds_pkg::ST_S2:   next_state = fcds_pkg::ST_S3;
      fcds_pkg::ST_S3:   next_state = rdy || xtype == fcds_pkg::XFER_VERIFY ?
                                      fcds_pkg::ST_S4 : fcds_pkg::ST_WAIT;
      fcds_pkg::ST_WAIT: if (rdy) next_state = fcds_pkg::ST_S4;
      fcds_pkg::ST_S4:   next_state = keep_on ? fcds_pkg::ST_S2
                                              : fcds_pkg::ST_IDLE;
      fcds_pkg::ST_R1:   next_state = fcds_pkg::ST_R2;
      fcds_pkg::ST_R2:   next_state = fcds_pkg::ST_R3;
      fcds_pkg::ST_R3:   if (rdy) next_state = fcds_pkg::ST_R4;
      fcds_pkg::ST_R4:   next_state = fcds_pkg::ST_W1;
      fcds_pkg::ST_W1:   next_state = fcds_pkg::ST_W2;
      fcds_pkg::ST_W2:   next_state = fcds_pkg::ST_W3;
      fcds_pkg::ST_W3:   if (rdy) next_state = fcds_pkg::ST_W4;
      fcds_pkg::ST_W4:   next_state = stop ? fcds_pkg::ST_IDLE
                                           : fcds_pkg::ST_R1;
      fcds_pkg::ST_CASC: if (!grant || !pending[chan])
                           next_state = fcds_pkg::ST_IDLE;
      default:           next_state = fcds_pkg::ST_IDLE;
    endcase
  end

  // Channel counters
  wire step_io  = state == fcds_pkg::ST_S4;
  wire auto_ch  = mode[xfer_ch][fcds_pkg::MODE_AUTO];
  always_comb begin
    ch_step   = '0;
    ch_reload = '0;
    if (step_io) begin
      ch_step[chan]   = 1'b1;
      ch_reload[chan] = (ch_wrap[chan] || ext_eop || eop_pend) && auto_ch;
    end
    if (state == fcds_pkg::ST_R4) begin
      ch_step[0]   = 1'b1;
      ch_reload[0] = ch_wrap[0] && mode[0][fcds_pkg::MODE_AUTO];
    end
    if (state == fcds_pkg::ST_W4) begin
      ch_step[1]   = 1'b1;
      ch_reload[1] = (ch_wrap[1] || ext_eop || eop_pend) &&
                     mode[1][fcds_pkg::MODE_AUTO];
    end
  end
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    fcds_chan u_chan (
      .i_sys_clk   (i_sys_clk),
      .i_rst_b     (i_rst_b),
      .i_wr_lo     (wr_chan && wsel_ch == g && !byte_ptr),
      .i_wr_hi     (wr_chan && wsel_ch == g && byte_ptr),
      .i_sel_cnt   (sel[0]),
      .i_data      (din),
      .i_step      (ch_step[g]),
      .i_hold_addr (g == 0 && cmd[fcds_pkg::CMDB_M2M] &&
                    cmd[fcds_pkg::CMDB_HOLD0]),
      .i_dec       (mode[g][fcds_pkg::MODE_DEC]),
      .i_reload    (ch_reload[g]),
      .o_addr      (ch_addr[g]),
      .o_count     (ch_count[g]),
      .o_wrap      (ch_wrap[g])
    );
  end

  // Control registers
  wire ends_svc = last && stop;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state    <= fcds_pkg::ST_IDLE;
      cmd      <= fcds_pkg::RST_CMD;
      mask     <= fcds_pkg::RST_MASK;
      sw_req   <= '0;
      tc_flag  <= '0;
      byte_ptr <= 1'b0;
      chan     <= 2'd0;
      eop_pend <= 1'b0;
      wr_d     <= 1'b1;
      rd_d     <= 1'b1;
      temp     <= 8'h00;
      for (int i = 0; i < NCH; i++) mode[i] <= 6'h00;
    end else if (mclr) begin
      state    <= fcds_pkg::ST_IDLE;
      cmd      <= fcds_pkg::RST_CMD;
      mask     <= fcds_pkg::RST_MASK;
      sw_req   <= '0;
      tc_flag  <= '0;
      byte_ptr <= 1'b0;
      eop_pend <= 1'b0;
      wr_d     <= wr_n;
      rd_d     <= rd_n;
    end else begin
      state <= next_state;
      wr_d  <= wr_n;
      rd_d  <= rd_n;
      if (state == fcds_pkg::ST_IDLE) chan <= pick;
      if (state == fcds_pkg::ST_R3 && rdy) temp <= din;
      if (ext_eop && state != fcds_pkg::ST_IDLE) eop_pend <= 1'b1;
      if (next_state == fcds_pkg::ST_IDLE) eop_pend <= 1'b0;
      if (wr_cmd) cmd <= din;
      if (wr_mode) mode[din[1:0]] <= din[7:2];
      if (wr_req) sw_req[din[1:0]] <= din[2];
      if (wr_msk1) mask[din[1:0]] <= din[2];
      if (wr_mall) mask <= din[3:0];
      if (clr_msk) mask <= '0;
      if (wr_chan) byte_ptr <= !byte_ptr;
      if (set_ptr) byte_ptr <= 1'b1;
      if (clr_ptr) byte_ptr <= 1'b0;
      if (rd_stat) tc_flag <= '0;
      if (ends_svc && cnt_end) begin
        tc_flag[xfer_ch] <= 1'b1;
        if (!auto_ch) mask[xfer_ch] <= 1'b1;
      end
      if (ends_svc) sw_req[xfer_ch] <= 1'b0;
    end
  end

  // Output flops
  wire active   = state != fcds_pkg::ST_IDLE && state != fcds_pkg::ST_HOLD &&
                  state != fcds_pkg::ST_CASC;
  wire io_phase = state == fcds_pkg::ST_S2 || state == fcds_pkg::ST_S3 ||
                  state == fcds_pkg::ST_WAIT || state == fcds_pkg::ST_S4;
  wire rd_ph    = state == fcds_pkg::ST_R2 || state == fcds_pkg::ST_R3;
  wire wr_ph    = state == fcds_pkg::ST_W3 || state == fcds_pkg::ST_W4;
  wire ack_on   = io_phase || state == fcds_pkg::ST_S1 ||
                  state == fcds_pkg::ST_CASC;
  wire ack_hi   = cmd[fcds_pkg::CMDB_CHAN_ACKNOWLEDGE_HI];
  wire strb_ph  = state == fcds_pkg::ST_S3 || state == fcds_pkg::ST_WAIT ||
                  state == fcds_pkg::ST_S4;
  wire mem_rd   = (strb_ph && xtype == fcds_pkg::XFER_READ) || rd_ph;
  wire mem_wr   = (strb_ph && xtype == fcds_pkg::XFER_WRITE) || wr_ph;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_bus_hold_request      <= 1'b0;
      o_chan_acknowledge      <= '1;
      o_addr                  <= 16'h0000;
      o_addr_oe               <= 1'b0;
      o_ctrl_oe               <= 1'b0;
      o_data                  <= 8'h00;
      o_data_oe               <= 1'b0;
      o_memory_read_strobe_n  <= 1'b1;
      o_memory_write_strobe_n <= 1'b1;
      o_io_read_strobe_n      <= 1'b1;
      o_io_write_strobe_n     <= 1'b1;
      o_end_of_process_n      <= 1'b1;
      o_end_of_process_oe     <= 1'b0;
      o_status                <= 8'h00;
    end else begin
      o_bus_hold_request <= state != fcds_pkg::ST_IDLE;
      for (int i = 0; i < NCH; i++)
        o_chan_acknowledge[i] <= (ack_on && !m2m && chan == i) ? ack_hi : !ack_hi;
      o_addr    <= (rd_ph || state == fcds_pkg::ST_R1) ? ch_addr[0] :
                   (m2m ? ch_addr[1] : ch_addr[chan]);
      o_addr_oe <= active;
      o_ctrl_oe <= active;
      o_data    <= temp;
      o_data_oe <= wr_ph;
      o_memory_read_strobe_n  <= !mem_rd;
      o_memory_write_strobe_n <= !mem_wr;
      o_io_read_strobe_n  <= !(strb_ph && xtype == fcds_pkg::XFER_WRITE);
      o_io_write_strobe_n <= !(strb_ph && xtype == fcds_pkg::XFER_READ);
      o_end_of_process_n  <= !(ends_svc && cnt_end);
      o_end_of_process_oe <= ends_svc && cnt_end;
      o_status <= {pending, tc_flag};
    end
  end
endmodule // fcds_core
`default_nettype wire

// ==== testbench/fcds_core_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module fcds_core_monitor #(
  parameter int NCH = 4
) (
  input wire logic           i_sys_clk,
  input wire logic           i_rst_b,
  input wire logic           i_ready,
  input wire logic           i_bus_hold_grant,
  input wire logic [15:0]    o_addr,
  input wire logic           o_addr_oe,
  input wire logic           o_data_oe,
  input wire logic           o_ctrl_oe,
  input wire logic           o_bus_hold_request,
  input wire logic [NCH-1:0] o_chan_acknowledge,
  input wire logic           o_memory_read_strobe_n,
  input wire logic           o_memory_write_strobe_n,
  input wire logic           o_io_read_strobe_n,
  input wire logic           o_io_write_strobe_n,
  input wire logic           o_end_of_process_n,
  input wire logic           o_end_of_process_oe
);
  wire mem_on = !o_memory_read_strobe_n || !o_memory_write_strobe_n;
  wire eop_on = !o_end_of_process_n && o_end_of_process_oe;
  wire ack_on = o_chan_acknowledge != {NCH{1'b1}};
  wire io_on  = !o_io_read_strobe_n || !o_io_write_strobe_n;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  property p_oe_hold;
    (o_addr_oe || o_ctrl_oe || o_data_oe) |-> o_bus_hold_request;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("bus driven idle");
  property p_io_wr;
    !o_io_read_strobe_n |-> !o_memory_write_strobe_n;
  endproperty
  a_io_wr: assert property (p_io_wr) else $error("io read alone");
  property p_io_rd;
    !o_io_write_strobe_n |-> !o_memory_read_strobe_n;
  endproperty
  a_io_rd: assert property (p_io_rd) else $error("io write alone");
  property p_mem_x;
    !(!o_memory_read_strobe_n && !o_memory_write_strobe_n);
  endproperty
  a_mem_x: assert property (p_mem_x) else $error("both mem strobes");
  property p_grant;
    mem_on |-> o_bus_hold_request && $past(i_bus_hold_grant, 2);
  endproperty
  a_grant: assert property (p_grant) else $error("strobe before grant");
  property p_eop_w;
    eop_on |=> !eop_on;
  endproperty
  a_eop_w: assert property (p_eop_w) else $error("end pulse too long");
  property p_eop_end;
    eop_on |-> ##[0:4] !o_bus_hold_request;
  endproperty
  a_eop_end: assert property (p_eop_end) else $error("no stop at end");
  property p_wait;
    io_on && !$past(io_on) && !$past(i_ready, 3)
      |-> ##1 $stable(o_addr) ##1 io_on;
  endproperty
  a_wait: assert property (p_wait) else $error("step during wait");
  property p_ack;
    ack_on |-> o_bus_hold_request && $onehot(~o_chan_acknowledge);
  endproperty
  a_ack: assert property (p_ack) else $error("bad acknowledge");
endmodule // fcds_core_monitor
bind fcds_core fcds_core_monitor #(.NCH(NCH)) mon_u (.i_sys_clk, .i_rst_b,
  .i_ready, .i_bus_hold_grant, .o_addr, .o_addr_oe, .o_data_oe, .o_ctrl_oe,
  .o_bus_hold_request, .o_chan_acknowledge, .o_memory_read_strobe_n,
  .o_memory_write_strobe_n, .o_io_read_strobe_n, .o_io_write_strobe_n,
  .o_end_of_process_n, .o_end_of_process_oe);
`default_nettype wire

// ==== testbench/fcds_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host side: grants the bus after a chosen delay
module fcds_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_bus_hold_request,
  input  wire logic [3:0] i_delay,
  output logic            o_bus_hold_grant
);
  logic [3:0] wait_cnt;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_cnt         <= 4'h0;
      o_bus_hold_grant <= 1'b0;
    end else if (!i_bus_hold_request) begin
      wait_cnt         <= 4'h0;
      o_bus_hold_grant <= 1'b0; // Release with request
    end else if (wait_cnt >= i_delay) begin
      o_bus_hold_grant <= 1'b1; // Grant only on request
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // fcds_host_model
`default_nettype wire

// ==== testbench/four_channel_dma_sequencer_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module four_channel_dma_sequencer_bench;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        gnt, rdy, eop_n, cs_n, rd_n, wr_n, hold, aoe, doe, coe;
  logic        memory_read_strobe, memory_write_strobe, io_read_strobe, io_write_strobe, eo, eoe;
  logic [3:0]  req, sel, dly, ack;
  logic [7:0]  din, odat, stat;
  logic [15:0] addr;
  logic [31:0] seed;
  int          errors, total_checks;
  fcds_core dut_u (.i_sys_clk(clk), .i_rst_b(rst_b), .i_chan_request(req),
    .i_bus_hold_grant(gnt), .i_ready(rdy), .i_end_of_process_n(eop_n),
    .i_chip_select_n(cs_n), .i_io_read_strobe_n(rd_n),
    .i_io_write_strobe_n(wr_n), .i_register_select_lines(sel),
    .i_data(din), .o_data(odat), .o_data_oe(doe), .o_addr(addr),
    .o_addr_oe(aoe), .o_bus_hold_request(hold), .o_chan_acknowledge(ack),
    .o_memory_read_strobe_n(memory_read_strobe), .o_memory_write_strobe_n(memory_write_strobe),
    .o_io_read_strobe_n(io_read_strobe), .o_io_write_strobe_n(io_write_strobe), .o_ctrl_oe(coe),
    .o_end_of_process_n(eo), .o_end_of_process_oe(eoe), .o_status(stat));
  fcds_host_model host_u (.i_sys_clk(clk), .i_rst_b(rst_b),
    .i_bus_hold_request(hold), .i_delay(dly), .o_bus_hold_grant(gnt));
  always #2.5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic test_done();
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_hold(logic v);
    int n;
    for (n = 0; n < 2000 && hold !== v; n++) cyc(1);
    if (hold !== v) begin
      errors++;
      test_done();
    end
  endtask
  task automatic acc(logic [3:0] s, logic [7:0] d, logic rd);
    cs_n = 1'b0; // Grant is low here
    sel = s;
    din = d;
    cyc(3);
    if (rd) rd_n = 1'b0;
    else wr_n = 1'b0;
    cyc(3);
    rd_n = 1'b1;
    wr_n = 1'b1;
    cyc(4);
    cs_n = 1'b1;
    cyc(1);
  endtask
  task automatic setup(logic [1:0] c, logic [7:0] m, logic [15:0] a,
                       logic [15:0] n);
    acc(4'hC, 8'h00, 1'b0); // Clear, then set pointer
    acc(4'hC, 8'h00, 1'b1);
    acc({1'b0, c, 1'b0}, a[15:8], 1'b0);
    acc({1'b0, c, 1'b0}, a[7:0], 1'b0);
    acc(4'hC, 8'h00, 1'b0);
    acc({1'b0, c, 1'b1}, n[7:0], 1'b0);
    acc({1'b0, c, 1'b1}, n[15:8], 1'b0);
    acc(4'hB, {m[7:2], c}, 1'b0);
    acc(4'hE, 8'h00, 1'b0);
  endtask
  task automatic run(logic [1:0] c, logic [1:0] sv, logic [1:0] ty,
                     logic dc, logic au, logic [15:0] n, int stop);
    logic [31:0] r;
    logic [15:0] ea;
    logic        st, pst, ph, es;
    int          k, hf, t;
    r = rnd();
    ea = r[15:0];
    dly = r[19:16];
    pst = 1'b1;
    ph = 1'b1;
    es = 1'b0;
    k = 0;
    hf = 0;
    setup(c, {sv, dc, au, ty, 2'b00}, r[15:0], n);
    req[c] = 1'b1; // Block drops it at the first strobe, demand at the stop count; otherwise held to the end
    wait_hold(1'b1);
    for (t = 0; t < 4000; t++) begin
      cyc(1);
      r = rnd();
      rdy = (ty == fcds_pkg::XFER_VERIFY) | r[0];
      st = (ty == fcds_pkg::XFER_WRITE) ? memory_write_strobe : memory_read_strobe;
      es = es | (!eo & eoe);
      if (!st && pst) begin
        chk("addr", addr, ea);
        chk("ack", 16'(ack[c]), 16'h0000);
        ea = dc ? ea - 16'h0001 : ea + 16'h0001;
        k++;
        if (sv == fcds_pkg::SVC_BLOCK) req[c] = 1'b0;
        if (k == stop && sv == fcds_pkg::SVC_DEMAND) req[c] = 1'b0;
        else if (k == stop) eop_n = 1'b0;
      end
      if (!hold && ph) hf++;
      pst = st;
      ph = hold;
      if (!hold && (es || (stop > 0 && k >= stop))) break;
    end
    if (t == 4000) begin
      errors++;
      test_done();
    end
    eop_n = 1'b1;
    if (stop > 0) chk("stop", 16'(k > stop + 1), 16'h0000);
    else begin
      chk("tc", 16'(stat[c]), 16'h0001);
      if (ty != fcds_pkg::XFER_VERIFY) chk("cnt", 16'(k), n + 16'h0001);
      req[c] = 1'b1;
      pst = 1'b0;
      repeat (20) begin
        cyc(1);
        pst = pst | hold;
      end
      chk("mask", 16'(pst), 16'(au));
    end
    if (sv == fcds_pkg::SVC_SINGLE && ty != 2'h0) chk("hf", 16'(hf), 16'(k));
    req[c] = 1'b0;
    wait_hold(1'b0);
    cyc(3);
  endtask
  initial begin
    seed = 32'h0000_0009;
    errors = 0;
    total_checks = 0;
    req = 4'h0;
    rdy = 1'b1;
    eop_n = 1'b1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    sel = 4'h0;
    din = 8'h00;
    dly = 4'h0;
    cyc(2);
    rst_b = 1'b1;
    cyc(2);
    chk("ack0", 16'(ack), 16'h000F);
    chk("idle", 16'({aoe, coe, doe, hold}), 16'h0000);
    acc(4'hD, 8'h00, 1'b0);
    req = 4'h1;
    cyc(20);
    chk("masked", 16'(hold), 16'h0000);
    req = 4'h0;
    run(2'h0, fcds_pkg::SVC_SINGLE, fcds_pkg::XFER_WRITE, 0, 1, 16'h0002, 0);
    run(2'h1, fcds_pkg::SVC_BLOCK, fcds_pkg::XFER_READ, 1, 0, 16'h0003, 0);
    run(2'h2, fcds_pkg::SVC_SINGLE, fcds_pkg::XFER_VERIFY, 0, 1, 16'h0000, 0);
    run(2'h3, fcds_pkg::SVC_DEMAND, fcds_pkg::XFER_WRITE, 0, 0, 16'h0028, 2);
    run(2'h2, fcds_pkg::SVC_BLOCK, fcds_pkg::XFER_WRITE, 1, 0, 16'h0028, 3);
    run(2'h3, fcds_pkg::SVC_DEMAND, fcds_pkg::XFER_READ, 0, 0, 16'h0000, 0);
    dly = 4'h0;
    setup(2'h1, {fcds_pkg::SVC_CASCADE, 6'h00}, 16'h0000, 16'h0000);
    req = 4'h2;
    wait_hold(1'b1);
    cyc(12);
    eop_n = 1'b0;
    cyc(12);
    chk("casc", 16'({hold, ack[1], aoe, coe}), 16'h0008);
    req = 4'h0;
    eop_n = 1'b1;
    wait_hold(1'b0);
    test_done();
  end
endmodule // four_channel_dma_sequencer_bench
`default_nettype wire
